// ===== sgd_pkg.sv
package sgd_pkg;

   // ****************************************
   // channel layout
   // ****************************************
   localparam int          CH_MAX     = 16;
   localparam int          CH_NARROW  = 4;
   localparam int          CH_W       = 4;
   localparam int          ADDR_W     = 10;
   localparam int          CH_SHIFT   = 5;
   localparam logic [9:0]  WIDE_BASE  = 10'h200;
   localparam logic [9:0]  NARROW_END = 10'h080;
   localparam logic [9:0]  FLASH_ADDR = 10'h080;
   localparam logic [9:0]  FLASH_DATA = 10'h084;

   // ****************************************
   // register offsets inside one channel
   // ****************************************
   localparam logic [4:0]  OFF_MAIN_CUR_ADDR = 5'h00;
   localparam logic [4:0]  OFF_MAIN_NXT_ADDR = 5'h04;
   localparam logic [4:0]  OFF_MAIN_CUR_CNT  = 5'h08;
   localparam logic [4:0]  OFF_MAIN_NXT_CNT  = 5'h0C;
   localparam logic [4:0]  OFF_LIST_CUR_ADDR = 5'h10;
   localparam logic [4:0]  OFF_LIST_NXT_ADDR = 5'h14;
   localparam logic [4:0]  OFF_LIST_CUR_CNT  = 5'h18;
   localparam logic [4:0]  OFF_LIST_NXT_CNT  = 5'h1C;

   // ****************************************
   // list next count and control fields
   // ****************************************
   localparam int          BIT_DONE     = 30;
   localparam int          BIT_START    = 29;
   localparam int          BIT_PG_EN    = 28;
   localparam int          BIT_ABORT    = 26;
   localparam int          BIT_MEM_RD   = 25;
   localparam int          BIT_MN_DONE  = 23;
   localparam int          BIT_MN_EMPTY = 22;
   localparam int          BIT_PG_INT   = 18;
   localparam int          BIT_CUR_PG   = 17;
   localparam int          BIT_NXT_PG   = 16;
   localparam int          CTL_LSB      = 16;
   localparam logic [15:0] CTL_KEEP     = 16'h9B00;
   localparam logic [15:0] RESET_CTL    = 16'h0000;

   // ****************************************
   // list entry and data path
   // ****************************************
   localparam int          ENTRY_PG_BIT = 16;
   localparam logic [15:0] ENTRY_BYTES  = 16'h0008;
   localparam logic [31:0] ENTRY_STEP   = 32'h0000_0008;
   localparam logic [31:0] WORD_STEP    = 32'h0000_0004;
   localparam logic [15:0] ONE_WORD     = 16'h0001;
   localparam int          DATA_W       = 32;
   localparam int          FIFO_DEPTH   = 16;

   typedef enum logic {FT_IDLE, FT_WAIT} sgd_fetch_type;
   typedef enum logic {MV_IDLE, MV_WAIT} sgd_move_type;

   function automatic logic chanHit(logic [ADDR_W-1:0] a, logic wide);
      chanHit = wide ? (a >= WIDE_BASE) : (a < NARROW_END);
   endfunction

   function automatic logic [CH_W-1:0] chanIndex(logic [ADDR_W-1:0] a);
      chanIndex = a[CH_SHIFT +: CH_W];
   endfunction

endpackage

// ===== sgd_fifo.sv
`timescale 1ns/1ps
module sgd_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store_q [DEPTH];
   logic [PW-1:0]    wrPtr_q;
   logic [PW-1:0]    rdPtr_q;
   logic [PW:0]      count_q;
   logic [PW:0]      count_d;
   logic             push;
   logic             pop;

   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outData  = store_q[rdPtr_q];
   assign count_d  = count_q + (PW+1)'(push) - (PW+1)'(pop);

   // flags kept as flops so the ready seen upstream is glitch free
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_q  <= '0;
         rdPtr_q  <= '0;
         count_q  <= '0;
         inReady  <= 1'b1;
         outValid <= 1'b0;
      end else begin
         if (push) wrPtr_q <= wrPtr_q + 1'b1;
         if (pop) rdPtr_q <= rdPtr_q + 1'b1;
         count_q  <= count_d;
         inReady  <= count_d != (PW+1)'(DEPTH);
         outValid <= count_d != '0;
      end
   end

   always_ff @(posedge clk) begin
      if (push) store_q[wrPtr_q] <= inData;
   end
endmodule // sgd_fifo

// ===== sgd_pick.sv
`timescale 1ns/1ps
module sgd_pick
   import sgd_pkg::*;
(
   input  wire logic [CH_MAX-1:0] req,
   output logic                   any,
   output logic      [CH_W-1:0]   idx
);
   // fixed priority, lowest channel first
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = CH_MAX-1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = CH_W'(i);
         end
      end
   end
endmodule // sgd_pick

// ===== sgd_dma_channels.sv
`timescale 1ns/1ps
module sgd_dma_channels
   import sgd_pkg::*;
#(
   parameter bit WIDE_BUILD = 1'b0
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   input  wire logic [31:0]       regWdata,
   output logic      [31:0]       regRdData_q,
   output logic                   regRdValid_q,
   output logic                   fetchReq_q,
   output logic      [31:0]       fetchAddr_q,
   input  wire logic              fetchValid,
   input  wire logic [63:0]       fetchData,
   output logic                   memValid_q,
   output logic      [31:0]       memAddr_q,
   output logic                   memRead_q,
   output logic      [31:0]       memWrData_q,
   input  wire logic              memAck,
   input  wire logic [31:0]       memRdData,
   input  wire logic [31:0]       userInData,
   input  wire logic              userInValid,
   output logic                   userInReady,
   output logic      [31:0]       userOutData_q,
   output logic                   userOutValid_q,
   input  wire logic              userOutReady
);
   // ****************************************
   // channel state
   // ****************************************
   logic [31:0] mainCurAddr_q [CH_MAX];
   logic [31:0] mainNxtAddr_q [CH_MAX];
   logic [15:0] curCount_q    [CH_MAX];
   logic [15:0] nxtCount_q    [CH_MAX];
   logic [31:0] listCurAddr_q [CH_MAX];
   logic [31:0] listNxtAddr_q [CH_MAX];
   logic [15:0] listRemain_q  [CH_MAX];
   logic [15:0] listNxtLen_q  [CH_MAX];
   logic [15:0] listNxtCtl_q  [CH_MAX];
   logic [15:0] listCurCtl_q  [CH_MAX];
   logic [CH_MAX-1:0] mainActive_q;
   logic [CH_MAX-1:0] mainNxtFull_q;
   logic [CH_MAX-1:0] curPg_q;
   logic [CH_MAX-1:0] nxtPg_q;
   logic [CH_MAX-1:0] listActive_q;
   logic [CH_MAX-1:0] listNxtValid_q;
   logic [CH_MAX-1:0] doneFlag_q;
   logic [CH_MAX-1:0] startRdy_q;
   logic [CH_MAX-1:0] pgInt_q;

   // ****************************************
   // host register decode
   // ****************************************
   logic [CH_W-1:0] regCh;
   logic [4:0]      regOff;
   logic            regHit;
   logic            flashWord;
   logic [CH_MAX-1:0] nxtAddrWr, nxtCntWr, abortHit, startCopy;
   logic [CH_MAX-1:0] mainCopy, mainFinish, beatEnd, listFinish;
   logic [CH_MAX-1:0] fetchNeed, fetchLoadV;
   logic [15:0]       ctlRead;
   logic [31:0]       rdMux;

   assign regCh     = chanIndex(regAddr);
   assign regOff    = regAddr[4:0];
   assign flashWord = regAddr == FLASH_ADDR || regAddr == FLASH_DATA;
   // flash update words never reach a channel
   assign regHit    = chanHit(regAddr, WIDE_BUILD) && !flashWord
                      && (WIDE_BUILD || int'(regCh) < CH_NARROW);

   // ****************************************
   // list fetch engine
   // ****************************************
   sgd_fetch_type fetchState_q;
   logic [CH_W-1:0] fetchCh_q;
   logic            fetchStale_q;
   logic            fetchAny;
   logic [CH_W-1:0] fetchIdx;
   logic            fetchLoad;

   assign fetchLoad = fetchState_q == FT_WAIT && fetchValid && !fetchStale_q;

   sgd_pick u_fetchPick (
      .req (fetchNeed),
      .any (fetchAny),
      .idx (fetchIdx)
   );

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fetchState_q <= FT_IDLE;
         fetchReq_q   <= 1'b0;
         fetchAddr_q  <= '0;
         fetchCh_q    <= '0;
         fetchStale_q <= 1'b0;
      end else begin
         unique case (fetchState_q)
            FT_IDLE: begin
               if (fetchAny) begin
                  fetchState_q <= FT_WAIT;
                  fetchReq_q   <= 1'b1;
                  fetchAddr_q  <= listCurAddr_q[fetchIdx];
                  fetchCh_q    <= fetchIdx;
                  // an abort landing on the issue edge must void the entry
                  fetchStale_q <= abortHit[fetchIdx];
               end
            end
            FT_WAIT: begin
               if (abortHit[fetchCh_q]) fetchStale_q <= 1'b1;
               if (fetchValid) begin
                  fetchState_q <= FT_IDLE;
                  fetchReq_q   <= 1'b0;
               end
            end
         endcase
      end
   end

   // ****************************************
   // data mover
   // ****************************************
   sgd_move_type moveState_q;
   logic [CH_W-1:0] moveCh_q;
   logic            moveAny;
   logic [CH_W-1:0] moveIdx;
   logic            moveDirRd;
   logic            moveZero;
   logic            fifoOutValid;
   logic [31:0]     fifoOutData;
   logic            issueRd, issueWr, beatDone;

   sgd_pick u_movePick (
      .req (mainActive_q),
      .any (moveAny),
      .idx (moveIdx)
   );

   sgd_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .reset_n  (reset_n),
      .inData   (userInData),
      .inValid  (userInValid),
      .inReady  (userInReady),
      .outData  (fifoOutData),
      .outValid (fifoOutValid),
      .outReady (issueWr)
   );

   // direction latched with the list
   assign moveDirRd = listCurCtl_q[moveIdx][BIT_MEM_RD-CTL_LSB];
   assign moveZero  = moveState_q == MV_IDLE && moveAny
                      && curCount_q[moveIdx] == '0;
   // a read beat only goes out when its word has a place to land
   assign issueRd   = moveState_q == MV_IDLE && moveAny && !moveZero
                      && moveDirRd && !userOutValid_q;
   assign issueWr   = moveState_q == MV_IDLE && moveAny && !moveZero
                      && !moveDirRd && fifoOutValid;
   assign beatDone  = moveState_q == MV_WAIT && memAck;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         moveState_q <= MV_IDLE;
         moveCh_q    <= '0;
         memValid_q  <= 1'b0;
         memAddr_q   <= '0;
         memRead_q   <= 1'b0;
         memWrData_q <= '0;
      end else begin
         if (issueRd || issueWr) begin
            moveState_q <= MV_WAIT;
            moveCh_q    <= moveIdx;
            memValid_q  <= 1'b1;
            memAddr_q   <= mainCurAddr_q[moveIdx];
            memRead_q   <= issueRd;
            memWrData_q <= fifoOutData;
         end else if (beatDone) begin
            moveState_q <= MV_IDLE;
            memValid_q  <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         userOutValid_q <= 1'b0;
         userOutData_q  <= '0;
      end else if (beatDone && memRead_q) begin
         userOutValid_q <= 1'b1;
         userOutData_q  <= memRdData;
      end else if (userOutReady) begin
         userOutValid_q <= 1'b0;
      end
   end

   // ****************************************
   // per-channel events
   // ****************************************
   always_comb begin
      for (int i = 0; i < CH_MAX; i++) begin
         nxtAddrWr[i]  = regWrite && regHit && int'(regCh) == i
                         && regOff == OFF_LIST_NXT_ADDR
                         && !listNxtValid_q[i];
         nxtCntWr[i]   = regWrite && regHit && int'(regCh) == i
                         && regOff == OFF_LIST_NXT_CNT && !listNxtValid_q[i];
         abortHit[i]   = regWrite && regHit && int'(regCh) == i
                         && regOff == OFF_LIST_NXT_CNT && regWdata[BIT_ABORT];
         startCopy[i]  = listNxtValid_q[i] && !listActive_q[i];
         mainCopy[i]   = mainNxtFull_q[i] && !mainActive_q[i];
         beatEnd[i]    = beatDone && int'(moveCh_q) == i && mainActive_q[i];
         mainFinish[i] = mainActive_q[i]
                         && ((beatEnd[i] && curCount_q[i] == ONE_WORD)
                         || (moveZero && int'(moveIdx) == i));
         fetchNeed[i]  = fetchState_q == FT_IDLE && listActive_q[i]
                         && listRemain_q[i] != '0 && !mainNxtFull_q[i];
         fetchLoadV[i] = fetchLoad && int'(fetchCh_q) == i;
         listFinish[i] = listActive_q[i] && listRemain_q[i] == '0
                         && !mainActive_q[i] && !mainNxtFull_q[i]
                         && !(fetchState_q == FT_WAIT
                         && int'(fetchCh_q) == i);
      end
   end

   // ****************************************
   // channel registers
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < CH_MAX; i++) begin
            mainCurAddr_q[i] <= '0;
            mainNxtAddr_q[i] <= '0;
            curCount_q[i]    <= '0;
            nxtCount_q[i]    <= '0;
            listCurAddr_q[i] <= '0;
            listNxtAddr_q[i] <= '0;
            listRemain_q[i]  <= '0;
            listNxtLen_q[i]  <= '0;
            listNxtCtl_q[i]  <= RESET_CTL;
            listCurCtl_q[i]  <= RESET_CTL;
         end
         mainActive_q   <= '0;
         mainNxtFull_q  <= '0;
         curPg_q        <= '0;
         nxtPg_q        <= '0;
         listActive_q   <= '0;
         listNxtValid_q <= '0;
         doneFlag_q     <= '0;
         startRdy_q     <= '1;
         pgInt_q        <= '0;
      end else begin
         for (int i = 0; i < CH_MAX; i++) begin
            if (nxtAddrWr[i]) listNxtAddr_q[i] <= regWdata;
            if (nxtCntWr[i]) begin
               listNxtCtl_q[i] <= regWdata[31:CTL_LSB] & CTL_KEEP;
               listNxtLen_q[i] <= regWdata[15:0];
               if (!regWdata[BIT_PG_EN]) pgInt_q[i] <= 1'b0;
               if (regWdata[BIT_START] && !regWdata[BIT_ABORT]) begin
                  listNxtValid_q[i] <= 1'b1;
                  startRdy_q[i]     <= 1'b0;
               end
            end
            if (startCopy[i]) begin
               listCurAddr_q[i]  <= listNxtAddr_q[i];
               listRemain_q[i]   <= listNxtLen_q[i];
               listCurCtl_q[i]   <= listNxtCtl_q[i];
               listActive_q[i]   <= 1'b1;
               listNxtValid_q[i] <= 1'b0;
               startRdy_q[i]     <= 1'b1;
               doneFlag_q[i]     <= 1'b0;
            end
            if (fetchLoadV[i]) begin
               mainNxtAddr_q[i] <= fetchData[63:32];
               nxtCount_q[i]    <= fetchData[15:0];
               nxtPg_q[i]       <= fetchData[ENTRY_PG_BIT];
               mainNxtFull_q[i] <= 1'b1;
               listCurAddr_q[i] <= listCurAddr_q[i] + ENTRY_STEP;
               // a ragged tail shorter than one entry ends the list
               listRemain_q[i]  <= listRemain_q[i] >= ENTRY_BYTES
                                   ? listRemain_q[i] - ENTRY_BYTES
                                   : '0;
            end
            if (mainCopy[i]) begin
               mainCurAddr_q[i] <= mainNxtAddr_q[i];
               curCount_q[i]    <= nxtCount_q[i];
               curPg_q[i]       <= nxtPg_q[i];
               mainActive_q[i]  <= 1'b1;
               mainNxtFull_q[i] <= 1'b0;
            end
            if (beatEnd[i]) begin
               mainCurAddr_q[i] <= mainCurAddr_q[i] + WORD_STEP;
               curCount_q[i]    <= curCount_q[i] - ONE_WORD;
            end
            // address stays one word past the last word used once idle
            if (mainFinish[i]) begin
               mainActive_q[i] <= 1'b0;
               if (curPg_q[i] && listNxtCtl_q[i][BIT_PG_EN-CTL_LSB]) begin
                  pgInt_q[i] <= 1'b1;
               end
            end
            if (listFinish[i]) begin
               listActive_q[i] <= 1'b0;
               doneFlag_q[i]   <= 1'b1;
            end
            if (abortHit[i]) begin
               listActive_q[i]   <= 1'b0;
               listNxtValid_q[i] <= 1'b0;
               mainActive_q[i]   <= 1'b0;
               mainNxtFull_q[i]  <= 1'b0;
               doneFlag_q[i]     <= 1'b0;
               startRdy_q[i]     <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // host read path
   // ****************************************
   always_comb begin
      ctlRead                            = listNxtCtl_q[regCh];
      ctlRead[BIT_DONE-CTL_LSB]          = doneFlag_q[regCh];
      ctlRead[BIT_START-CTL_LSB]         = startRdy_q[regCh];
      ctlRead[BIT_ABORT-CTL_LSB]         = 1'b0;
      ctlRead[BIT_MN_DONE-CTL_LSB]       = !mainActive_q[regCh];
      ctlRead[BIT_MN_EMPTY-CTL_LSB]      = !mainNxtFull_q[regCh];
      ctlRead[BIT_PG_INT-CTL_LSB]        = pgInt_q[regCh];
      ctlRead[BIT_CUR_PG-CTL_LSB]        = curPg_q[regCh];
      ctlRead[BIT_NXT_PG-CTL_LSB]        = nxtPg_q[regCh];
   end

   // same eight words for every channel
   always_comb begin
      unique case (regOff)
         OFF_MAIN_CUR_ADDR: rdMux = mainCurAddr_q[regCh];
         OFF_MAIN_NXT_ADDR: rdMux = mainNxtAddr_q[regCh];
         OFF_MAIN_CUR_CNT:  rdMux = {ctlRead, curCount_q[regCh]};
         OFF_MAIN_NXT_CNT:  rdMux = {ctlRead, nxtCount_q[regCh]};
         OFF_LIST_CUR_ADDR: rdMux = listCurAddr_q[regCh];
         OFF_LIST_NXT_ADDR: rdMux = listNxtAddr_q[regCh];
         OFF_LIST_CUR_CNT:  rdMux = {ctlRead, listRemain_q[regCh]};
         OFF_LIST_NXT_CNT:  rdMux = {ctlRead, listNxtLen_q[regCh]};
         default:           rdMux = '0;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData_q  <= '0;
         regRdValid_q <= 1'b0;
      end else begin
         regRdValid_q <= regRead;
         if (regRead) regRdData_q <= regHit ? rdMux : '0;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence startTaken;
      nxtCntWr[0] && regWdata[BIT_START] && !regWdata[BIT_ABORT];
   endsequence
   sequence startPending;
      listNxtValid_q[0] && !startRdy_q[0];
   endsequence

   start_strobe_a: assert property (startTaken |=> startPending)
      else $error("start write not held pending");
   abort_clear_a: assert property (abortHit[0] |=> !listActive_q[0]
      && !doneFlag_q[0] && !listNxtValid_q[0] && !mainActive_q[0])
      else $error("abort left channel busy");
   main_addr_copy_a: assert property (mainCopy[0] |=>
      mainCurAddr_q[0] == $past(mainNxtAddr_q[0]))
      else $error("main address not copied");
   main_cnt_copy_a: assert property (mainCopy[0] && !abortHit[0] |=>
      curCount_q[0] == $past(nxtCount_q[0]) && mainActive_q[0])
      else $error("main count not copied");
   main_ro_a: assert property (!mainCopy[0] && !beatEnd[0] |=>
      $stable(mainCurAddr_q[0]))
      else $error("main address changed without engine");
   fetch_fill_a: assert property (fetchLoadV[0] && !abortHit[0] |=>
      mainNxtFull_q[0] && mainNxtAddr_q[0] == $past(fetchData[63:32])
      && listCurAddr_q[0] == $past(listCurAddr_q[0]) + ENTRY_STEP)
      else $error("entry not loaded");
   list_copy_a: assert property (startCopy[0] && !abortHit[0] |=>
      listCurAddr_q[0] == $past(listNxtAddr_q[0]) && startRdy_q[0]
      && !doneFlag_q[0])
      else $error("list address not copied");
   list_done_a: assert property (listFinish[0] && !abortHit[0] |=>
      doneFlag_q[0] ##1 (doneFlag_q[0] || $past(startCopy[0])
      || $past(abortHit[0])))
      else $error("done flag not raised");
   page_flag_a: assert property (mainFinish[0] && curPg_q[0]
      && listNxtCtl_q[0][BIT_PG_EN-CTL_LSB] |=> pgInt_q[0])
      else $error("page flag missed");
   fetch_hold_a: assert property (fetchReq_q && !fetchValid |=>
      fetchReq_q)
      else $error("fetch request dropped");
endmodule // sgd_dma_channels

// ===== sgd_host_mem.sv
`timescale 1ns/1ps
module sgd_host_mem (
   input  logic        clk,
   input  logic        fetchReq,
   input  logic [31:0] fetchAddr,
   output logic        fetchValid = 1'b0,
   output logic [63:0] fetchData,
   input  logic        memValid,
   input  logic [31:0] memAddr,
   output logic        memAck = 1'b0,
   output logic [31:0] memRdData
);
   logic slow = 1'b0;
   // ****************************************
   // entry: page at address*16, two words
   // ****************************************
   assign fetchData = fetchValid ? {fetchAddr << 4, 32'h0000_0002}
                                 : ~{fetchAddr << 4, 32'h0000_0002};
   // idle data is inverted so stale values never match
   assign memRdData = memAck ? memAddr : ~memAddr;
   always @(posedge clk) begin
      slow       <= ~slow;
      fetchValid <= fetchReq && !fetchValid;
      // acks only land on every other cycle, so a beat may wait one cycle
      memAck     <= memValid && !memAck && slow;
   end
endmodule // sgd_host_mem

// ===== test_scatter_gather_dma_channels.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
   fails++; $display("Error %s exp %h got %h", n, e, s); end end
module test_scatter_gather_dma_channels;
   import sgd_pkg::*;
   logic clk = 0, reset_n = 0, regWrite = 0, regRead = 0;
   logic [9:0] regAddr = 0;
   logic [31:0] regWdata = 0, regRdData_q, fetchAddr_q, memAddr_q;
   logic [31:0] memRdData, userOutData_q, first, d;
   logic [63:0] fetchData;
   logic fetchReq_q, fetchValid, memValid_q, memAck, userOutValid_q;
   logic memRead, rdValid;
   int fails = 0, cmp_count = 0, beats = 0, i;
   logic [9:0]  ra [4] = '{10'h01C, 10'h03C, 10'h008, 10'h080};
   logic [31:0] rv [4] = '{32'h20C0_0000, 32'h20C0_0000, 32'h20C0_0000, 32'h0};
   always #2.5 clk = ~clk;
   sgd_dma_channels dut (.clk(clk), .reset_n(reset_n),
      .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWdata(regWdata), .regRdData_q(regRdData_q),
      .regRdValid_q(rdValid), .fetchReq_q(fetchReq_q),
      .fetchAddr_q(fetchAddr_q), .fetchValid(fetchValid),
      .fetchData(fetchData), .memValid_q(memValid_q),
      .memAddr_q(memAddr_q), .memRead_q(memRead), .memWrData_q(),
      .memAck(memAck), .memRdData(memRdData), .userInData(32'h0),
      .userInValid(1'b0), .userInReady(), .userOutData_q(userOutData_q),
      .userOutValid_q(userOutValid_q), .userOutReady(1'b1));
   sgd_host_mem host (.clk(clk), .fetchReq(fetchReq_q),
      .fetchAddr(fetchAddr_q), .fetchValid(fetchValid),
      .fetchData(fetchData), .memValid(memValid_q),
      .memAddr(memAddr_q), .memAck(memAck), .memRdData(memRdData));
   always @(posedge clk) if (userOutValid_q) begin
      if (beats == 0) first <= userOutData_q;
      beats <= beats + 1;
   end
   task automatic rd(input logic [9:0] a);
      @(posedge clk) begin regAddr <= a; regRead <= 1; end
      @(posedge clk) regRead <= 0;
      #1 d = regRdData_q;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      @(posedge clk) begin regAddr <= a; regWdata <= v; regWrite <= 1; end
      @(posedge clk) regWrite <= 0;
   endtask
   task automatic test_done;
      if (fails == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin repeat (20000) @(posedge clk); fails++; test_done; end
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1;
      // ****************************************
      // reset values and channel map
      // ****************************************
      for (i = 0; i < 4; i++) begin
         rd(ra[i]);
         `CHK("reg", rv[i], d)
         `CHK("valid", 1'b1, rdValid)
      end
      wr(10'h000, 32'h1234_5678);
      rd(10'h000); `CHK("ro", 32'h0, d)
      wr(10'h014, 32'h0000_0100);
      rd(10'h014); `CHK("nxt", 32'h0000_0100, d)
      // ****************************************
      // one-entry list, memory read direction
      // ****************************************
      wr(10'h01C, 32'h2200_0008);
      i = 0;
      do begin rd(10'h01C); i++; end while (d[30] !== 1'b1 && i < 200);
      `CHK("done", 1'b1, d[30])
      `CHK("beats", 2, beats)
      `CHK("data", 32'h0000_1000, first)
      `CHK("dir", 1'b1, memRead)
      // ****************************************
      // abort a running list
      // ****************************************
      wr(10'h014, 32'h0000_0200);
      wr(10'h01C, 32'h2200_0010);
      wr(10'h01C, 32'h0400_0000);
      rd(10'h01C); `CHK("abort", 3'b000, {d[30], d[29], d[26]})
      // an entry fetched as the abort lands must move no data
      repeat (30) @(posedge clk);
      `CHK("stale", 2, beats)
      test_done;
   end
endmodule // test_scatter_gather_dma_channels
